// ===== sim/sks_op_model.sv
// operator entry model: edits and confirms the switch setting
`default_nettype none
module sks_op_model (
   input  wire logic ref_clk_i,
   output var logic  val_o,
   output var logic  ok_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      val_o = 1'b0;
      ok_o  = 1'b0;
   end
   task automatic edit(input logic v, input logic ok);
      @(posedge ref_clk_i);
      val_o <= v;
      ok_o  <= ok;
      @(posedge ref_clk_i);
      ok_o  <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// testbench for the soft pushbutton/switch block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, srst = 1'b1, ps = 1'b0, en = 1'b0, md = 1'b1, so = 1'b0, rt = 1'b0, ce = 1'b1;
   wire logic sv, sk, q, son, mo;
   int bad_count = 0, compares = 0;
   always #2.5 clk = ~clk;
   sks_op_model OP (.ref_clk_i(clk), .val_o(sv), .ok_o(sk));
   sks_top DUT (.ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .prog_start_i(ps), .en_i(en),
      .mode_latch_i(md), .start_on_i(so), .retentive_i(rt), .switch_val_i(sv),
      .switch_ok_i(sk), .q_o(q), .switch_on_o(son), .mode_latch_o(mo));
   task automatic wrap_up;
      if (bad_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_q(input logic v);
      for (int i = 0; i < 8 && q !== v; i++) cyc(1);
      chk(q, v);
      if (q !== v) wrap_up();
   endtask
   task automatic t_latch;
      OP.edit(1'b1, 1'b1);
      @(posedge clk) en <= 1'b1;
      wait_q(1'b1);
      chk(son, 1'b1);
      cyc(3);
      chk(q, 1'b1);
      @(posedge clk) en <= 1'b0;
      wait_q(1'b0);
   endtask
   task automatic t_edit;
      @(posedge clk) en <= 1'b1;
      wait_q(1'b1);
      OP.edit(1'b0, 1'b0);
      cyc(3);
      chk(q, 1'b1);
      OP.edit(1'b0, 1'b1);
      wait_q(1'b0);
      @(posedge clk) en <= 1'b0;
   endtask
   task automatic t_push;
      @(posedge clk) md <= 1'b0;
      OP.edit(1'b1, 1'b1);
      @(posedge clk) en <= 1'b1;
      wait_q(1'b1);
      cyc(1);
      chk(q, 1'b0);
      @(posedge clk) en <= 1'b0;
      md <= 1'b1;
   endtask
   task automatic t_freeze;
      OP.edit(1'b1, 1'b1);
      @(posedge clk) en <= 1'b1;
      wait_q(1'b1);
      @(posedge clk) ce <= 1'b0;
      en <= 1'b0;
      cyc(3);
      chk(q, 1'b1);
      @(posedge clk) ce <= 1'b1;
      wait_q(1'b0);
   endtask
   task automatic t_start;
      @(posedge clk) so <= 1'b1;
      ps <= 1'b1;
      @(posedge clk) ps <= 1'b0;
      wait_q(1'b1);
      @(posedge clk) rt <= 1'b1;
      so <= 1'b0;
      srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      wait_q(1'b1);
      @(posedge clk) rt <= 1'b0;
      so <= 1'b0;
      srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      cyc(2);
      chk(q, 1'b0);
   endtask
   initial begin
      cyc(11);
      chk(mo, 1'b1);
      @(posedge clk) srst <= 1'b0;
      cyc(2);
      t_latch();
      t_edit();
      t_push();
      t_freeze();
      t_start();
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== verilog/sks_cfg_if.sv
// interface: operator parameter entry carried to the entry latch
`default_nettype none
interface sks_cfg_if;
   logic switch_val;
   logic switch_ok;
   logic switch_on;
   logic switch_off_evt;
   modport src (output switch_val, output switch_ok, input switch_on, input switch_off_evt);
   modport latch (input switch_val, input switch_ok, output switch_on, output switch_off_evt);
endinterface
`default_nettype wire

// ===== verilog/sks_entry.sv
// module: confirmed switch setting latch
`default_nettype none
module sks_entry (
   input  wire logic  ref_clk_i,
   input  wire logic  srst_i,
   input  wire logic  ce_i,
   sks_cfg_if.latch   cfg
);
   logic switch_ff;
   logic offevt_ff;
   wire  nxt_switch = (cfg.switch_ok) ? cfg.switch_val : switch_ff; // RULE10
   wire  nxt_offevt = cfg.switch_ok & ~cfg.switch_val;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         switch_ff <= sks_pkg::RST_SWITCH;
         offevt_ff <= 1'b0;
      end else if (ce_i) begin
         switch_ff <= nxt_switch;
         offevt_ff <= nxt_offevt;
      end
   end

   assign cfg.switch_on      = switch_ff;
   assign cfg.switch_off_evt = offevt_ff;

   unconfirmed_hold_a : assert property (@(posedge ref_clk_i) disable iff (srst_i) // RULE10
      (ce_i && !cfg.switch_ok) |=> $stable(switch_ff))
      else $error("setting changed without confirmation");
endmodule
`default_nettype wire

// ===== verilog/sks_pkg.sv
// package: constants for the soft pushbutton/switch block
`default_nettype none
package sks_pkg;
   localparam logic RST_MODE_LATCH = 1'b1;
   localparam logic RST_SWITCH     = 1'b0;
   localparam logic RST_OUT        = 1'b0;
   localparam logic RST_EN_PREV    = 1'b0;
   localparam int   PULSE_CYCLES   = 1;
   typedef enum logic [1:0] {
      SKS_COLD = 2'b00,
      SKS_RUN  = 2'b01
   } sks_state_t;
endpackage
`default_nettype wire

// ===== verilog/sks_top.sv
// module: soft pushbutton/switch evaluated once per program cycle
`default_nettype none
//
// Function
// RULE1: a rising edge on the enable with the confirmed setting on sets the output.
// RULE2: the set condition is the same in pushbutton and switch configuration.
// RULE3: a falling edge on the enable clears the output.
// RULE4: in pushbutton configuration the output clears one cycle after being set.
// RULE5: a confirmed off selection clears the output.
// RULE6: a configuration bit selects one-cycle pushbutton or latching switch action.
// RULE7: without retentivity the output starts in the configured start state at program start.
// RULE8: after power loss the output takes the start state, or keeps its value when retentive.
// RULE9: the default configuration is latching switch action.
// RULE10: the setting applies from the cycle after confirmation onward; unconfirmed edits do nothing.
module sks_top (
   input  wire logic  ref_clk_i,
   input  wire logic  srst_i,
   input  wire logic  ce_i,
   input  wire logic  prog_start_i,
   input  wire logic  en_i,
   input  wire logic  mode_latch_i,
   input  wire logic  start_on_i,
   input  wire logic  retentive_i,
   input  wire logic  switch_val_i,
   input  wire logic  switch_ok_i,
   output logic       q_o,
   output logic       switch_on_o,
   output logic       mode_latch_o
);
   sks_cfg_if cfg_bus ();
   assign cfg_bus.switch_val = switch_val_i;
   assign cfg_bus.switch_ok  = switch_ok_i;

   sks_entry u_entry (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .cfg       (cfg_bus.latch)
   );

   logic                q_ff;
   logic                en_prev_ff;
   logic                mode_ff;
   logic                ret_q_ff;
   logic                sw_ff;
   sks_pkg::sks_state_t state_ff;

   // edge detection on the enable input
   function automatic logic edge_of(input logic cur, input logic prev, input logic rising);
      edge_of = rising ? (cur & ~prev) : (~cur & prev);
   endfunction

   wire en_rise  = edge_of(en_i, en_prev_ff, 1'b1);
   wire en_fall  = edge_of(en_i, en_prev_ff, 1'b0);
   wire set_cond = en_rise & cfg_bus.switch_on;               // RULE1 RULE2
   wire pulse_end = ~mode_ff & q_ff;                          // RULE4 RULE6
   wire clr_cond = en_fall | pulse_end | cfg_bus.switch_off_evt; // RULE3 RULE5
   wire init_q   = retentive_i ? ret_q_ff : start_on_i;       // RULE7 RULE8

   logic nxt_q;
   always_comb begin
      nxt_q = q_ff;
      case (state_ff)
         sks_pkg::SKS_COLD: nxt_q = init_q;
         sks_pkg::SKS_RUN: begin
            if (prog_start_i)
               nxt_q = init_q;
            else if (set_cond)
               nxt_q = 1'b1;
            else if (clr_cond)
               nxt_q = 1'b0;
         end
         default: nxt_q = 1'b0;
      endcase
   end

   // retained copy survives srst (power loss) when retentive
   always_ff @(posedge ref_clk_i) begin
      if (ce_i && !srst_i)
         ret_q_ff <= nxt_q;                   // RULE8
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q_ff       <= sks_pkg::RST_OUT;
         en_prev_ff <= sks_pkg::RST_EN_PREV;
         mode_ff    <= sks_pkg::RST_MODE_LATCH; // RULE9
         state_ff   <= sks_pkg::SKS_COLD;
         sw_ff      <= sks_pkg::RST_SWITCH;
      end else if (ce_i) begin
         q_ff       <= nxt_q;
         en_prev_ff <= en_i;
         mode_ff    <= mode_latch_i;           // RULE6
         state_ff   <= sks_pkg::SKS_RUN;
         sw_ff      <= cfg_bus.switch_on;
      end
   end

   assign q_o          = q_ff;
   assign switch_on_o  = sw_ff;
   assign mode_latch_o = mode_ff;

   sequence s_run_set;
      ce_i && state_ff == sks_pkg::SKS_RUN && !prog_start_i && set_cond;
   endsequence

   sequence s_pulse_set;
      ce_i && !mode_ff && state_ff == sks_pkg::SKS_RUN && !prog_start_i && set_cond;
   endsequence

   sequence s_pulse_idle;
      ce_i && !prog_start_i && !set_cond;
   endsequence

   sequence s_warm_reset;
      srst_i && retentive_i && ce_i;
   endsequence

   sequence s_cold_retentive;
      !srst_i && ce_i && state_ff == sks_pkg::SKS_COLD && retentive_i;
   endsequence

   rise_sets_q_a : assert property ( // RULE1
      @(posedge ref_clk_i) disable iff (srst_i)
      s_run_set |=> q_ff)
      else $error("output not set on enable rise");

   refused_rise_a : assert property ( // RULE1
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_RUN && !prog_start_i && en_rise && !cfg_bus.switch_on && !q_ff)
      |=> !q_ff)
      else $error("output set with setting off");

   pulse_mode_set_a : assert property ( // RULE2
      @(posedge ref_clk_i) disable iff (srst_i)
      s_pulse_set |=> q_ff)
      else $error("pushbutton output not set on enable rise");

   fall_clears_q_a : assert property ( // RULE3
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_RUN && !prog_start_i && en_fall) |=> !q_ff)
      else $error("output not cleared on enable fall");

   pulse_one_cycle_a : assert property ( // RULE4
      @(posedge ref_clk_i) disable iff (srst_i)
      s_pulse_set ##1 s_pulse_idle |=> !q_ff)
      else $error("pushbutton output held too long");

   pulse_no_hold_a : assert property ( // RULE4
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && !mode_ff && state_ff == sks_pkg::SKS_RUN && !prog_start_i && q_ff && !set_cond)
      |=> !q_ff)
      else $error("pushbutton output not released");

   off_clears_q_a : assert property ( // RULE5
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_RUN && !prog_start_i && !set_cond
       && cfg_bus.switch_off_evt) |=> !q_ff)
      else $error("confirmed off did not clear output");

   off_event_a : assert property ( // RULE5
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && switch_ok_i && !switch_val_i)
      |=> (!cfg_bus.switch_on && cfg_bus.switch_off_evt))
      else $error("confirmed off not recorded");

   mode_follows_a : assert property ( // RULE6
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && !srst_i)
      |=> (mode_ff == $past(mode_latch_i)))
      else $error("mode not taken from configuration");

   switch_holds_a : assert property ( // RULE6
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && mode_ff && state_ff == sks_pkg::SKS_RUN && q_ff && !prog_start_i && en_i
       && en_prev_ff && !cfg_bus.switch_off_evt) |=> q_ff)
      else $error("latched output dropped");

   start_state_a : assert property ( // RULE7
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_COLD && !retentive_i) |=> (q_ff == $past(start_on_i)))
      else $error("start state not applied");

   prog_start_a : assert property ( // RULE7
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_RUN && prog_start_i && !retentive_i)
      |=> (q_ff == $past(start_on_i)))
      else $error("program start did not apply start state");

   retain_q_a : assert property ( // RULE8
      @(posedge ref_clk_i)
      s_warm_reset ##1 s_cold_retentive
      |=> (q_ff == $past(ret_q_ff)))
      else $error("retentive state lost");

   latch_default_a : assert property ( // RULE9
      @(posedge ref_clk_i)
      $past(srst_i) |-> mode_ff)
      else $error("default mode not latching");

   reset_values_a : assert property ( // RULE9
      @(posedge ref_clk_i)
      srst_i
      |=> (!q_ff && mode_ff && !sw_ff))
      else $error("reset values not applied");

   switch_on_set_a : assert property ( // RULE10
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && switch_ok_i && switch_val_i)
      |=> cfg_bus.switch_on)
      else $error("confirmed on not recorded");

   switch_mirror_a : assert property ( // RULE10
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && !srst_i)
      |=> (sw_ff == $past(cfg_bus.switch_on)))
      else $error("setting output does not follow setting");

   q_idle_hold_a : assert property ( // RULE10
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_RUN && !prog_start_i && !set_cond && !clr_cond)
      |=> (q_ff == $past(q_ff)))
      else $error("output moved without cause");

   // clock enable low freezes every register while srst is low
   freeze_hold_a : assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      !ce_i
      |=> ($stable(q_ff) && $stable(mode_ff) && $stable(sw_ff) && $stable(en_prev_ff)))
      else $error("state moved while clock enable low");

   cold_leaves_a : assert property ( // RULE7
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && state_ff == sks_pkg::SKS_COLD)
      |=> (state_ff == sks_pkg::SKS_RUN))
      else $error("start cycle not left");
endmodule
`default_nettype wire
